// [level_sync.sv]
module level_sync
   import spi_slave_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Level in and out
   input wire logic i_level,
   output logic o_level
);

   sync_state_t st_r;
   sync_state_t st_nxt;

   // ==========================================================
   // Two stages; only the second one is read outside
   always_comb begin
      st_nxt = st_r;
      st_nxt.meta = i_level;
      st_nxt.stable = st_r.meta;
   end

   // Reset to "chip select high" so no false rising edge after reset
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         st_r <= '{meta: 1'b1, stable: 1'b1};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_level = st_r.stable;

endmodule

// [spi_master_model.sv]
module spi_master_model (
   // Serial link toward the slave
   output logic o_sck,
   output logic o_sdi,
   output logic o_cs_n,
   // Serial link from the slave
   input wire logic i_sdo
);
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================
   // Idle bus
   initial begin
      o_sck = 1'b1;
      o_cs_n = 1'b1;
      o_sdi = 1'b0;
   end

   // ==========================================================
   // One frame of n bits, msb first
   task automatic xfer(input logic [79:0] v, input int n, output logic [79:0] got);
      got = '0;
      o_cs_n = 1'b0;
      #20;
      for (int k = n - 1; k >= 0; k--) begin
         o_sck = 1'b0;
         o_sdi = v[k];
         #15;
         o_sck = 1'b1;
         got = {got[78:0], i_sdo};
         #15;
      end
      o_cs_n = 1'b1;
      // Released line flips so stale data never looks valid
      o_sdi = ~o_sdi;
      #100;
   endtask
endmodule

// [spi_register_access_slave.sv]
// Functional notes
// - Datagram is 40 bits: address byte, four data bytes
// - Bit 39 set means write, clear means read
// - Every register moves as full 32-bit word
// - Response shifted out in every datagram
// - Read data returns in the next datagram
// - After a write, write data echoes back
// - Read datagram data ignored, only address kept
// - Response bits 39..32 carry the status byte
// - Status captured at access end, sent next
// - Status 7..4: stop right, left, position, velocity
// - Status 3 standstill, 2 stall detect flag
// - Status 1 driver error, 0 reset seen
// - Values right aligned, two's complement, fields kept
// - Sample on rising SCK, drive after falling
// - Most significant bit first both directions
// - Extra bits reappear on output 40 clocks later
// - Chip select rise executes shift register command
// - Only final 40 bits form the command
// - Mode 3: idle high, change fall, capture rise
`include "spi_slave_consts.svh"

module spi_register_access_slave (
   // System clock and reset
   input wire logic I_SYS_CLK,
   input wire logic I_RESET,
   // Serial link
   input wire logic I_SCK,
   input wire logic I_SDI,
   input wire logic I_CHIP_SELECT_N,
   output logic O_SDO,
   // Register access port
   output logic O_WR_STROBE,
   output logic O_RD_STROBE,
   output logic [6:0] O_REG_ADDR,
   output logic [31:0] O_WR_DATA,
   // Register read return, sampled at the end of the read strobe cycle
   input wire logic [31:0] I_RD_DATA,
   // Status sources
   input wire logic I_STOP_RIGHT,
   input wire logic I_STOP_LEFT,
   input wire logic I_POS_REACHED,
   input wire logic I_VEL_REACHED,
   input wire logic I_STANDSTILL,
   input wire logic I_STALL_DETECT_FLAG,
   input wire logic I_DRV_ERROR,
   input wire logic I_RESET_SEEN
);
   import spi_slave_pkg::*;

   // ==========================================================
   // Helpers

   // Full response word as shifted out
   function automatic logic [39:0] build_response(input logic [7:0] status,
                                                  input logic [31:0] data);
      build_response = {status, data};
   endfunction

   // Status byte from the motion and driver flags
   function automatic logic [7:0] pack_status(input logic stop_r,
                                              input logic stop_l,
                                              input logic pos_ok,
                                              input logic vel_ok,
                                              input logic still,
                                              input logic stall,
                                              input logic drv_err,
                                              input logic rst_seen);
      logic [7:0] s;
      s = `STATUS_RST;
      s[`ST_STOP_RIGHT] = stop_r;
      s[`ST_STOP_LEFT] = stop_l;
      s[`ST_POS_REACHED] = pos_ok;
      s[`ST_VEL_REACHED] = vel_ok;
      s[`ST_STANDSTILL] = still;
      s[`ST_STALL] = stall;
      s[`ST_DRV_ERROR] = drv_err;
      s[`ST_RESET_SEEN] = rst_seen;
      pack_status = s;
   endfunction

   // ==========================================================
   // Declarations
   sys_state_t sys_r;
   sys_state_t sys_nxt;
   link_state_t link_r;
   link_state_t link_nxt;
   logic in_frame_r;
   logic sdo_bit_r;
   logic fell_r;
   logic cs_high_sync;
   logic cs_rise;
   logic frame_complete;
   logic [39:0] response;
   logic link_frame_rst;

   assign response = build_response(sys_r.status, sys_r.resp_data);
   // Frame-local flags clear whenever chip select is high
   assign link_frame_rst = I_RESET | I_CHIP_SELECT_N;

   // ==========================================================
   // Link domain: receive shifter on rising SCK
   always_comb begin
      link_nxt = link_r;
      if (!in_frame_r) begin
         // First edge of a frame preloads the response above the new bit
         link_nxt.shift = {response[38:0], I_SDI};
         link_nxt.bit_cnt = 6'h01;
         // New frame id lets the system side skip a pulse without clocks
         link_nxt.frame_tog = ~link_r.frame_tog;
      end else begin
         link_nxt.shift = {link_r.shift[38:0], I_SDI};
         if (link_r.bit_cnt != `DGRAM_FULL) begin
            link_nxt.bit_cnt = link_r.bit_cnt + 6'h01;
         end
      end
   end

   // Shifter and count survive chip select high so the system side
   // can read them after the frame; SCK is idle then.
   always_ff @(posedge I_SCK or posedge I_RESET) begin
      if (I_RESET) begin
         link_r <= '{shift: `SR_RST, bit_cnt: `CNT_RST, frame_tog: 1'b0};
      end else begin
         link_r <= link_nxt;
      end
   end

   always_ff @(posedge I_SCK or posedge link_frame_rst) begin
      if (link_frame_rst) begin
         in_frame_r <= 1'b0;
      end else begin
         in_frame_r <= 1'b1;
      end
   end

   // ==========================================================
   // Link domain: output bit after falling SCK
   // The shifter's top bit is the response for clocks 2 to 40
   // and the delayed input after that; clock 1 sends first_bit.
   always_ff @(negedge I_SCK or posedge link_frame_rst) begin
      if (link_frame_rst) begin
         sdo_bit_r <= 1'b0;
         fell_r <= 1'b0;
      end else begin
         // Mode 3 changes data on the leading falling edge, so bit 39
         // is loaded there and SDO stays a single flop
         if (fell_r) begin
            sdo_bit_r <= link_r.shift[`RW_BIT];
         end else begin
            sdo_bit_r <= sys_r.first_bit;
         end
         fell_r <= 1'b1;
      end
   end

   assign O_SDO = sdo_bit_r;

   // ==========================================================
   // Chip select into the system domain
   level_sync u_cs_sync (
      .i_clk(I_SYS_CLK),
      .i_reset(I_RESET),
      .i_level(I_CHIP_SELECT_N),
      .o_level(cs_high_sync)
   );

   assign cs_rise = cs_high_sync & ~sys_r.cs_high_prev;
   // Count is quasi-static here: SCK stopped before chip select rose
   assign frame_complete = (link_r.bit_cnt == `DGRAM_FULL) &&
                           (link_r.frame_tog != sys_r.done_tog);

   // ==========================================================
   // System domain: command execution
   always_comb begin
      sys_nxt = sys_r;
      sys_nxt.cs_high_prev = cs_high_sync;
      sys_nxt.wr_strobe = 1'b0;
      sys_nxt.rd_strobe = 1'b0;
      sys_nxt.first_bit = response[`RW_BIT];
      if (cs_rise) begin
         // Any chip select rise uses up the frame, complete or not
         sys_nxt.done_tog = link_r.frame_tog;
      end
      unique case (sys_r.state)
         EXEC_IDLE: begin
            if (cs_rise && frame_complete) begin
               sys_nxt.reg_addr = link_r.shift[`ADDR_MSB:`ADDR_LSB];
               sys_nxt.status = pack_status(I_STOP_RIGHT, I_STOP_LEFT,
                                            I_POS_REACHED, I_VEL_REACHED,
                                            I_STANDSTILL, I_STALL_DETECT_FLAG,
                                            I_DRV_ERROR, I_RESET_SEEN);
               if (link_r.shift[`RW_BIT]) begin
                  sys_nxt.wr_strobe = 1'b1;
                  sys_nxt.wr_data = link_r.shift[`DATA_MSB:`DATA_LSB];
                  sys_nxt.resp_data = link_r.shift[`DATA_MSB:`DATA_LSB];
               end else begin
                  // Dummy data of a read is never stored
                  sys_nxt.rd_strobe = 1'b1;
                  sys_nxt.state = EXEC_RD_WAIT;
               end
            end
         end
         EXEC_RD_WAIT: begin
            // Word taken whole and unaltered; alignment is the owner's
            sys_nxt.resp_data = I_RD_DATA;
            sys_nxt.state = EXEC_IDLE;
         end
         default: begin
            sys_nxt.state = EXEC_IDLE;
         end
      endcase
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         sys_r <= '{cs_high_prev: 1'b1,
                    state: EXEC_IDLE,
                    wr_strobe: 1'b0,
                    rd_strobe: 1'b0,
                    reg_addr: `ADDR_RST,
                    wr_data: `RESP_DATA_RST,
                    resp_data: `RESP_DATA_RST,
                    status: `STATUS_RST,
                    first_bit: 1'b0,
                    done_tog: 1'b0};
      end else begin
         sys_r <= sys_nxt;
      end
   end

   // ==========================================================
   // Register port
   assign O_WR_STROBE = sys_r.wr_strobe;
   assign O_RD_STROBE = sys_r.rd_strobe;
   assign O_REG_ADDR = sys_r.reg_addr;
   assign O_WR_DATA = sys_r.wr_data;

endmodule

// [spi_register_access_slave_properties.sv]
module spi_slave_checker (
   // Clock and reset
   input wire logic I_SYS_CLK,
   input wire logic I_RESET,
   // Watched ports
   input wire logic I_SCK,
   input wire logic I_CHIP_SELECT_N,
   input wire logic I_STOP_RIGHT,
   input wire logic O_SDO,
   input wire logic O_WR_STROBE,
   input wire logic O_RD_STROBE,
   input wire logic [6:0] O_REG_ADDR,
   input wire logic [31:0] O_WR_DATA
);
   timeunit 1ns;
   timeprecision 100ps;
   logic stb;
   logic sck_seen;
   logic stop_d;
   logic st7_q;
   assign stb = O_WR_STROBE | O_RD_STROBE;

   // ==========================================================
   // Helpers
   // Cleared by chip select, so the first rising SCK of a frame is known
   always_ff @(posedge I_SCK or posedge I_CHIP_SELECT_N) begin
      if (I_CHIP_SELECT_N) begin
         sck_seen <= 1'b0;
      end else begin
         sck_seen <= 1'b1;
      end
   end

   // Status bit 7 as latched at the strobe edge
   always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         stop_d <= 1'b0;
         st7_q <= 1'b0;
      end else begin
         stop_d <= I_STOP_RIGHT;
         if (stb) begin
            st7_q <= stop_d;
         end
      end
   end

   // ==========================================================
   // Command execution
   one_strobe_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
      !(O_WR_STROBE && O_RD_STROBE)) else $error("both strobes high");
   wr_pulse_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
      O_WR_STROBE |=> !O_WR_STROBE) else $error("write strobe too long");
   strobe_gap_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
      stb |=> !stb [*8]) else $error("strobes too close");
   cs_first_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
      stb |-> I_CHIP_SELECT_N && $past(I_CHIP_SELECT_N, 2)) else $error("strobe before cs rise");
   addr_cause_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
      $changed(O_REG_ADDR) |-> stb) else $error("address moved without command");
   wdata_cause_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
      $changed(O_WR_DATA) |-> O_WR_STROBE) else $error("write data moved without write");
   rd_pulse_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
      O_RD_STROBE |=> !O_RD_STROBE) else $error("read strobe too long");

   // ==========================================================
   // Serial out
   sdo_status_a: assert property (@(posedge I_SCK) disable iff (I_RESET)
      !sck_seen |-> O_SDO == st7_q) else $error("status bit not on serial out");
endmodule

bind spi_register_access_slave spi_slave_checker u_checker (.I_SYS_CLK, .I_RESET, .I_SCK,
   .I_CHIP_SELECT_N, .I_STOP_RIGHT, .O_SDO, .O_WR_STROBE, .O_RD_STROBE, .O_REG_ADDR,
   .O_WR_DATA);

// [spi_slave_consts.svh]
`ifndef SPI_SLAVE_CONSTS_SVH
`define SPI_SLAVE_CONSTS_SVH

// ==========================================================
// Datagram layout
`define DGRAM_BITS 40
`define DGRAM_CNT_W 6
`define DGRAM_FULL 6'h28
`define RW_BIT 39
`define ADDR_MSB 38
`define ADDR_LSB 32
`define DATA_MSB 31
`define DATA_LSB 0
`define ADDR_W 7
`define DATA_W 32
`define STATUS_W 8

// ==========================================================
// Status byte positions
`define ST_STOP_RIGHT 7
`define ST_STOP_LEFT 6
`define ST_POS_REACHED 5
`define ST_VEL_REACHED 4
`define ST_STANDSTILL 3
`define ST_STALL 2
`define ST_DRV_ERROR 1
`define ST_RESET_SEEN 0

// ==========================================================
// Reset values
`define RESP_DATA_RST 32'h0000_0000
`define STATUS_RST 8'h00
`define ADDR_RST 7'h00
`define CNT_RST 6'h00
`define SR_RST 40'h00_0000_0000

`endif

// [spi_slave_pkg.sv]
package spi_slave_pkg;

   // ==========================================================
   // Command execution states
   typedef enum logic [1:0] {
      EXEC_IDLE,
      EXEC_RD_WAIT
   } exec_state_t;

   // ==========================================================
   // System clock domain state
   typedef struct packed {
      logic cs_high_prev;
      exec_state_t state;
      logic wr_strobe;
      logic rd_strobe;
      logic [6:0] reg_addr;
      logic [31:0] wr_data;
      logic [31:0] resp_data;
      logic [7:0] status;
      logic first_bit;
      logic done_tog;
   } sys_state_t;

   // ==========================================================
   // Link clock domain state (rising SCK)
   typedef struct packed {
      logic [39:0] shift;
      logic [5:0] bit_cnt;
      logic frame_tog;
   } link_state_t;

   // ==========================================================
   // Synchroniser state
   typedef struct packed {
      logic meta;
      logic stable;
   } sync_state_t;

endpackage

// [test_spi_register_access_slave.sv]
module test_spi_register_access_slave;
   timeunit 1ns;
   timeprecision 100ps;
   logic I_SYS_CLK, I_RESET, I_SCK, I_SDI, I_CHIP_SELECT_N, O_SDO, O_WR_STROBE, O_RD_STROBE;
   logic [6:0] O_REG_ADDR;
   logic [31:0] O_WR_DATA, I_RD_DATA;
   logic [7:0] st;
   logic [31:0] regs [128];
   logic [31:0] mdl [128];
   logic [39:0] exp_resp;
   int error_cnt = 0, compares = 0, wr_n = 0, rd_n = 0, ewr = 0, erd = 0;

   // ==========================================================
   // Design and far side
   spi_register_access_slave DUT (.I_SYS_CLK, .I_RESET, .I_SCK, .I_SDI, .I_CHIP_SELECT_N,
      .O_SDO, .O_WR_STROBE, .O_RD_STROBE, .O_REG_ADDR, .O_WR_DATA, .I_RD_DATA,
      .I_STOP_RIGHT(st[7]), .I_STOP_LEFT(st[6]), .I_POS_REACHED(st[5]),
      .I_VEL_REACHED(st[4]), .I_STANDSTILL(st[3]), .I_STALL_DETECT_FLAG(st[2]),
      .I_DRV_ERROR(st[1]), .I_RESET_SEEN(st[0]));
   spi_master_model master (.o_sck(I_SCK), .o_sdi(I_SDI), .o_cs_n(I_CHIP_SELECT_N),
      .i_sdo(O_SDO));

   initial begin
      I_SYS_CLK = 1'b0;
      forever #4 I_SYS_CLK = ~I_SYS_CLK;
   end

   // Register file: read data valid in the same cycle as the strobe
   always @(posedge I_SYS_CLK) begin
      #1;
      if (O_WR_STROBE === 1'b1) begin
         regs[O_REG_ADDR] = O_WR_DATA;
         wr_n++;
      end
      if (O_RD_STROBE === 1'b1) rd_n++;
      I_RD_DATA = regs[O_REG_ADDR];
   end

   // ==========================================================
   // Tasks
   task automatic chk(input logic [79:0] got, input logic [79:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic run(input logic [79:0] v, input int n);
      logic [79:0] got;
      logic [79:0] msk;
      @(posedge I_SYS_CLK);
      #1;
      st = 8'($urandom);
      master.xfer(v, n, got);
      if (n >= 40) begin
         msk = (80'h1 << (n - 40)) - 80'h1;
         chk(got >> (n - 40), {40'h0, exp_resp});
         chk(got & msk, (v >> 40) & msk);
         if (v[39]) begin
            mdl[v[38:32]] = v[31:0];
            exp_resp = {st, v[31:0]};
            ewr++;
         end else begin
            exp_resp = {st, mdl[v[38:32]]};
            erd++;
         end
      end
      chk(80'(wr_n), 80'(ewr));
      chk(80'(rd_n), 80'(erd));
   endtask

   task automatic results();
      if (error_cnt == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Sequence
   initial begin
      #200000;
      error_cnt++;
      results();
   end

   initial begin
      I_RESET = 1'b1;
      st = '0;
      exp_resp = '0;
      void'($urandom(32'h3e66));
      for (int i = 0; i < 128; i++) begin
         regs[i] = $urandom;
         mdl[i] = regs[i];
      end
      repeat (8) @(posedge I_SYS_CLK);
      #1;
      I_RESET = 1'b0;
      repeat (4) @(posedge I_SYS_CLK);
      run(80'h21_0000_0000, 40);
      run(80'h21_0000_0000, 40);
      run(80'ha7_00ab_cdef, 40);
      run(80'ha7_0012_3456, 40);
      run(80'h00_0000_0000, 0);
      run(80'h27_ffff_ffff, 39);
      run(80'h27_5555_5555, 40);
      run(80'h00_0000_0000, 8);
      run(80'h2a_0000_0000, 40);
      for (int i = 0; i < 16; i++) begin
         run(80'({$urandom, $urandom, $urandom}), 40 + (i % 3) * 4);
      end
      results();
   end
endmodule
